// file: design/srm_defines.svh
// Register offsets, field positions, reset values and timing of the standby RAM controller.
// Assumes inclusion by bare name from the controller's design files.
//
// Functional notes
// - Array base aligned to array size, 4K/2K
// - Array takes byte, word and long accesses
// - Unimplemented control addresses read zero, ignore writes
// - Base writes only when stopped and unlocked
// - Base lock sets once, clears only by reset
// - Base in forbidden range keeps array unreachable
// - Space field low bit: program-only when set
// - Space field upper bit never affects acceptance
// - Byte and even word access one bus cycle, long and odd word two
// - Backup supply active refuses every array access
// - Reset: stop set, both spaces, base/lock cleared
// - Reset waits for byte or word access
// - Long access: reset in first word cuts
`ifndef SRM_DEFINES_SVH
`define SRM_DEFINES_SVH

`define SRM_OFF_CFG     3'h0
`define SRM_OFF_TST     3'h2
`define SRM_OFF_BAH     3'h4
`define SRM_OFF_BAL     3'h6
`define SRM_CFG_STOP    15
`define SRM_CFG_LOCK    14
`define SRM_CFG_SP_HI   13
`define SRM_CFG_SP_LO   12
`define SRM_RST_STOP    1'b1
`define SRM_RST_SPACE   2'h0
`define SRM_RST_BASE    24'h000000
`define SRM_BAD_LO      24'h080000
`define SRM_BAD_HI      24'h7FFFFF
`define SRM_REG_BASE    24'hFFFB40
`define SRM_ARRAY_BYTES 4096
`define SRM_CLK_PER_BUS 2

`endif

// file: design/srm_mem.sv
// Static RAM array, 16 bits wide, with byte lanes and registered read data.
// Assumes one operation per enabled cycle; lane 1 is the even byte.
`timescale 1ns/1ps
`default_nettype none
module srm_mem #(
  parameter int WORDS = 2048,
  parameter int AW    = 11
) (
  input  wire logic          clk_sys,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [1:0]    be,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  output logic      [15:0]   rdata
);
  logic [15:0] mem [WORDS];

  always_ff @(posedge clk_sys) begin
    if (en) begin
      if (we && be[1]) begin
        mem[addr][15:8] <= wdata[15:8];
      end
      if (we && be[0]) begin
        mem[addr][7:0] <= wdata[7:0];
      end
      if (!we) begin
        rdata <= mem[addr];
      end
    end
  end
endmodule
`default_nettype wire

// file: design/srm_pkg.sv
// Types shared by the standby RAM controller files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package srm_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} srm_size_t;
  typedef enum {ST_IDLE, ST_C1A, ST_C1B, ST_C2A, ST_C2B} srm_state_t;
endpackage
`default_nettype wire

// file: design/srm_top.sv
// Standby RAM controller: control registers, array decode and access sequencing.
// Assumes a same-clock access master, a plain register port and a backup-supply pin.
`timescale 1ns/1ps
`default_nettype none
`include "srm_defines.svh"
module srm_top #(
  parameter int          ARRAY_BYTES = `SRM_ARRAY_BYTES,
  parameter logic [23:0] REG_BASE    = `SRM_REG_BASE
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        soft_reset,
  input  wire logic        backup_supply,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        acc_req,
  input  wire logic [23:0] acc_addr,
  input  wire logic [1:0]  acc_size,
  input  wire logic        acc_wr,
  input  wire logic        acc_prog,
  input  wire logic [31:0] acc_wdata,
  output logic             acc_busy,
  output logic             acc_done,
  output logic      [31:0] acc_rdata
);
  localparam int AW = $clog2(ARRAY_BYTES);
  localparam logic [15:0] LO_MASK = 16'(~((32'd1 << AW) - 32'd1));

  // ************************************************
  // Registers and decode
  // ************************************************
  logic        stop;
  logic        base_lock_bit;
  logic [1:0]  space_select_field;
  logic [7:0]  ram_base_high_reg;
  logic [15:0] ram_base_low_reg;
  logic [15:0] ram_config_reg;
  logic [23:0] base24;
  logic        backup_s1;
  logic        backup_s2;
  logic        rst_pend;
  logic        apply_rst;
  logic        bad_range;
  logic        arr_on;
  logic        regs_hidden;
  logic        hit;
  logic        start;
  logic        base_open;
  srm_pkg::srm_state_t state;
  srm_pkg::srm_state_t next_state;
  srm_pkg::srm_size_t  x_size;
  srm_pkg::srm_size_t  in_size;
  logic        x_bx;
  logic        x_wr;
  logic        x_two;
  logic [23:0] x_addr;
  logic [31:0] x_wdata;
  logic [31:0] rd_acc;
  logic [31:0] next_rd;
  logic [15:0] wd16;
  logic [15:0] mrd;
  logic        mem_en;
  logic        in_bx;
  logic        in_two;
  logic        cut_long;

  assign ram_config_reg = {stop, base_lock_bit, space_select_field, 12'h000};
  assign base24    = {ram_base_high_reg, ram_base_low_reg};
  assign bad_range = (base24 >= `SRM_BAD_LO) && (base24 <= `SRM_BAD_HI);
  assign arr_on    = !stop && !backup_s2 && !bad_range;
  // Registers under the array vanish while it is live
  assign regs_hidden = arr_on && (REG_BASE[23:AW] == base24[23:AW]);
  // The upper space bit is deliberately not looked at
  assign hit = arr_on && (acc_addr[23:AW] == base24[23:AW])
               && (acc_addr[23:3] != REG_BASE[23:3])
               && (!space_select_field[0] || acc_prog);
  assign apply_rst = rst_pend && (state == srm_pkg::ST_IDLE);
  assign start = clk_en && (state == srm_pkg::ST_IDLE) && acc_req && hit
                 && !rst_pend && !soft_reset;
  assign base_open = stop && !base_lock_bit;
  assign in_size = srm_pkg::srm_size_t'(acc_size);
  assign in_bx   = (in_size == srm_pkg::SZ_BYTE)
                   || (in_size == srm_pkg::SZ_WORD && acc_addr[0]);
  assign in_two  = (in_size == srm_pkg::SZ_LONG)
                   || (in_size == srm_pkg::SZ_WORD && acc_addr[0]);
  assign cut_long = (x_size == srm_pkg::SZ_LONG) && (rst_pend || soft_reset);

  // Pin crossing; only the second stage is read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      backup_s1 <= 1'b0;
      backup_s2 <= 1'b0;
    end else if (clk_en) begin
      backup_s1 <= backup_supply;
      backup_s2 <= backup_s1;
    end
  end

  // Soft reset is held off while an access runs; a pending clear wins over a new request
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rst_pend <= 1'b0;
    end else if (clk_en) begin
      rst_pend <= soft_reset || (rst_pend && !apply_rst);
    end
  end

  // ************************************************
  // Control register writes
  // ************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stop               <= `SRM_RST_STOP;
      base_lock_bit      <= 1'b0;
      space_select_field <= `SRM_RST_SPACE;
      ram_base_high_reg  <= 8'(`SRM_RST_BASE >> 16);
      ram_base_low_reg   <= 16'(`SRM_RST_BASE);
    end else if (clk_en) begin
      if (apply_rst) begin
        stop               <= `SRM_RST_STOP;
        base_lock_bit      <= 1'b0;
        space_select_field <= `SRM_RST_SPACE;
        ram_base_high_reg  <= 8'(`SRM_RST_BASE >> 16);
        ram_base_low_reg   <= 16'(`SRM_RST_BASE);
      end else if (reg_wr && !regs_hidden) begin
        if (reg_addr == `SRM_OFF_CFG) begin
          stop               <= reg_wdata[`SRM_CFG_STOP];
          space_select_field <= reg_wdata[`SRM_CFG_SP_HI:`SRM_CFG_SP_LO];
          if (reg_wdata[`SRM_CFG_LOCK]) begin
            base_lock_bit <= 1'b1;
          end
        end
        if (reg_addr == `SRM_OFF_BAH && base_open) begin
          ram_base_high_reg <= reg_wdata[7:0];
        end
        if (reg_addr == `SRM_OFF_BAL && base_open) begin
          ram_base_low_reg <= reg_wdata & LO_MASK;
        end
      end
    end
  end

  // Read data stand one cycle; everything unmapped or hidden reads zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd && !regs_hidden) begin
        case (reg_addr)
          `SRM_OFF_CFG: reg_rdata <= ram_config_reg;
          `SRM_OFF_BAH: reg_rdata <= {8'h00, ram_base_high_reg};
          `SRM_OFF_BAL: reg_rdata <= ram_base_low_reg;
          default:      reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ************************************************
  // Array access sequencer
  // ************************************************
  // Each bus cycle is two clocks: issue, then capture
  always_comb begin
    next_state = state;
    case (state)
      srm_pkg::ST_IDLE: begin
        if (start) begin
          next_state = srm_pkg::ST_C1A;
        end
      end
      srm_pkg::ST_C1A: next_state = srm_pkg::ST_C1B;
      srm_pkg::ST_C1B: begin
        next_state = (x_two && !cut_long) ? srm_pkg::ST_C2A : srm_pkg::ST_IDLE;
      end
      srm_pkg::ST_C2A: next_state = srm_pkg::ST_C2B;
      srm_pkg::ST_C2B: next_state = srm_pkg::ST_IDLE;
      default:         next_state = srm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state    <= srm_pkg::ST_IDLE;
      acc_busy <= 1'b0;
    end else if (clk_en) begin
      state    <= next_state;
      acc_busy <= next_state != srm_pkg::ST_IDLE;
    end
  end

  // Request capture; a long word at an odd address is treated as even
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      x_size  <= srm_pkg::SZ_BYTE;
      x_bx    <= 1'b0;
      x_two   <= 1'b0;
      x_wr    <= 1'b0;
      x_addr  <= 24'h000000;
      x_wdata <= 32'h00000000;
    end else if (clk_en) begin
      if (start) begin
        x_size  <= in_size;
        x_bx    <= in_bx;
        x_two   <= in_two;
        x_wr    <= acc_wr;
        x_addr  <= (in_size == srm_pkg::SZ_LONG) ? {acc_addr[23:1], 1'b0} : acc_addr;
        x_wdata <= acc_wdata;
      end else if (state == srm_pkg::ST_C1B) begin
        x_addr <= x_addr + (x_bx ? 24'h000001 : 24'h000002);
      end
    end
  end

  always_comb begin
    if (x_bx) begin
      wd16 = {2{(x_size == srm_pkg::SZ_BYTE || state == srm_pkg::ST_C2A)
                ? x_wdata[7:0] : x_wdata[15:8]}};
    end else begin
      wd16 = (x_size == srm_pkg::SZ_WORD || state == srm_pkg::ST_C2A)
             ? x_wdata[15:0] : x_wdata[31:16];
    end
  end

  assign next_rd = x_bx ? {rd_acc[23:0], (x_addr[0] ? mrd[7:0] : mrd[15:8])}
                        : {rd_acc[15:0], mrd};
  assign mem_en  = clk_en && (state == srm_pkg::ST_C1A || state == srm_pkg::ST_C2A);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_acc    <= 32'h00000000;
      acc_rdata <= 32'h00000000;
      acc_done  <= 1'b0;
    end else if (clk_en) begin
      acc_done <= 1'b0;
      if (start) begin
        rd_acc <= 32'h00000000;
      end else if (state == srm_pkg::ST_C1B || state == srm_pkg::ST_C2B) begin
        rd_acc <= next_rd;
        if (next_state == srm_pkg::ST_IDLE) begin
          acc_rdata <= next_rd;
          acc_done  <= 1'b1;
        end
      end
    end
  end

  srm_mem #(
    .WORDS (ARRAY_BYTES / 2),
    .AW    (AW - 1)
  ) u_mem (
    .clk_sys (clk_sys),
    .en      (mem_en),
    .we      (x_wr),
    .be      (x_bx ? (x_addr[0] ? 2'h1 : 2'h2) : 2'h3),
    .addr    (x_addr[AW-1:1]),
    .wdata   (wd16),
    .rdata   (mrd)
  );

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_go_short;
    start && !in_two;
  endsequence
  sequence s_go_long;
    start && (in_size == srm_pkg::SZ_LONG);
  endsequence

  property p_base_guard;
    clk_en && reg_wr && (reg_addr == `SRM_OFF_BAH || reg_addr == `SRM_OFF_BAL)
      && !base_open && !apply_rst |=> base24 == $past(base24);
  endproperty
  a_base_guard: assert property (p_base_guard) else $error("base changed while closed");
  property p_lock_once;
    base_lock_bit && !apply_rst |=> base_lock_bit;
  endproperty
  a_lock_once: assert property (p_lock_once) else $error("lock cleared by write");
  property p_unimpl;
    clk_en && reg_rd && reg_addr == `SRM_OFF_TST |=> reg_rdata == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented read not zero");
  property p_stop_refuse;
    clk_en && state == srm_pkg::ST_IDLE && acc_req && stop |=> !acc_busy;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("stopped array answered");
  property p_backup;
    clk_en && state == srm_pkg::ST_IDLE && acc_req && backup_s2 |=> !acc_busy;
  endproperty
  a_backup: assert property (p_backup) else $error("access on backup supply");
  property p_range;
    clk_en && state == srm_pkg::ST_IDLE && acc_req && bad_range |=> !acc_busy;
  endproperty
  a_range: assert property (p_range) else $error("forbidden base answered");
  property p_prog;
    clk_en && state == srm_pkg::ST_IDLE && acc_req && space_select_field[0] && !acc_prog
      |=> !acc_busy;
  endproperty
  a_prog: assert property (p_prog) else $error("data access in program-only");
  property p_short;
    s_go_short ##1 clk_en ##1 clk_en |=> acc_done && !acc_busy;
  endproperty
  a_short: assert property (p_short) else $error("short access not two clocks");
  property p_long;
    s_go_long ##1 (clk_en && !soft_reset)[*2] ##1 clk_en[*2] |=> acc_done;
  endproperty
  a_long: assert property (p_long) else $error("long access not four clocks");
  property p_cut;
    clk_en && state == srm_pkg::ST_C1B && x_size == srm_pkg::SZ_LONG && rst_pend
      |=> state == srm_pkg::ST_IDLE && acc_done;
  endproperty
  a_cut: assert property (p_cut) else $error("long not cut after first word");
  property p_hold;
    clk_en && state == srm_pkg::ST_C1B && x_size == srm_pkg::SZ_WORD && x_bx && rst_pend
      |=> state == srm_pkg::ST_C2A;
  endproperty
  a_hold: assert property (p_hold) else $error("word cut by reset");
  property p_rst_vals;
    clk_en && apply_rst |=> stop && !base_lock_bit && space_select_field == 2'h0
      && base24 == 24'h000000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule
`default_nettype wire

// file: dv/srm_host.sv
// Host model: issues array accesses on the controller's access port.
// Assumes the same clock as the controller; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module srm_host (
  input  wire logic        clk_sys,
  output logic             acc_req,
  output logic      [23:0] acc_addr,
  output logic      [1:0]  acc_size,
  output logic             acc_wr,
  output logic             acc_prog,
  output logic      [31:0] acc_wdata,
  input  wire logic        acc_done,
  input  wire logic [31:0] acc_rdata
);
  // ****************************************
  // Access task
  // ****************************************
  initial begin
    acc_req   = 1'b0;
    acc_addr  = 24'h000000;
    acc_size  = 2'h0;
    acc_wr    = 1'b0;
    acc_prog  = 1'b0;
    acc_wdata = 32'h00000000;
  end

  // Waits for done before anything else is issued; no done in 8 cycles means refused
  task automatic acc(input logic [23:0] a, input logic [1:0] sz, input logic w,
                     input logic p, input logic [31:0] wd,
                     output logic [31:0] rd, output int cyc);
    @(posedge clk_sys);
    acc_req   <= 1'b1;
    acc_addr  <= a;
    acc_size  <= sz;
    acc_wr    <= w;
    acc_prog  <= p;
    acc_wdata <= wd;
    @(posedge clk_sys);
    acc_req <= 1'b0;
    cyc = 1;
    #1;
    while (acc_done !== 1'b1 && cyc < 8) begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    rd = acc_rdata;
    // Released address and write-data lines show a changed value, not the last one
    acc_addr  <= ~a;
    acc_wdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// file: dv/standby_ram_module_test.sv
// Bench for the standby RAM controller: register and array sequences.
// Assumes srm_top and srm_host compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module standby_ram_module_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        soft_reset = 1'b0;
  logic        backup_supply = 1'b0;
  logic        clk_en = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        acc_req;
  logic [23:0] acc_addr;
  logic [1:0]  acc_size;
  logic        acc_wr;
  logic        acc_prog;
  logic [31:0] acc_wdata;
  logic        acc_busy;
  logic        acc_done;
  logic [31:0] acc_rdata;
  logic [31:0] rd;
  int          cyc;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  srm_top DUT (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .soft_reset(soft_reset),
    .backup_supply(backup_supply), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_addr(acc_addr), .acc_size(acc_size), .acc_wr(acc_wr), .acc_prog(acc_prog),
    .acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata));

  srm_host host (.clk_sys(clk_sys), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_size(acc_size), .acc_wr(acc_wr), .acc_prog(acc_prog), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_rdata(acc_rdata));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Maps the array at 034000 and starts it; a base in 080000..7FFFFF would hide it
  task automatic map_run;
    wr(3'h4, 16'h0003);
    wr(3'h6, 16'h4000);
    wr(3'h0, 16'h0000);
  endtask

  task automatic op(input logic [23:0] a, input logic [1:0] sz, input logic w,
                    input logic p, input logic [31:0] d, input int c);
    logic [31:0] m;
    m = (sz == 2'h0) ? 32'h000000FF : (sz == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
    host.acc(a, sz, w, p, d, rd, cyc);
    `CHK(cyc, c)
    `CHK(acc_busy, 1'b0)
    if (!w && c < 8) `CHK(rd & m, d)
  endtask

  task automatic soft_case(input logic [23:0] a, input int dly, input logic [1:0] sz,
                           input int c, input logic [31:0] m, input logic [31:0] e);
    map_run();
    fork
      host.acc(a, sz, 1'b0, 1'b0, 32'h00000000, rd, cyc);
      begin
        repeat (dly) @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
      end
    join
    `CHK(cyc, c)
    `CHK(rd & m, e)
    chk_reg(3'h0, 16'h8000);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    chk_reg(3'h0, 16'h8000);
    chk_reg(3'h4, 16'h0000);
    chk_reg(3'h6, 16'h0000);
    wr(3'h2, 16'hFFFF);
    wr(3'h7, 16'hFFFF);
    chk_reg(3'h2, 16'h0000);
    chk_reg(3'h7, 16'h0000);
    chk_reg(3'h1, 16'h0000);
    wr(3'h4, 16'h0003);
    wr(3'h6, 16'h4FFF);
    chk_reg(3'h6, 16'h4000);
    chk_reg(3'h4, 16'h0003);
    op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h0, 8);
    wr(3'h0, 16'h0000);
    wr(3'h4, 16'h0055);
    chk_reg(3'h4, 16'h0003);
    op(24'h034000, 2'h2, 1'b1, 1'b0, 32'h11223344, 5);
    op(24'h034005, 2'h0, 1'b1, 1'b0, 32'h000000AA, 3);
    op(24'h034006, 2'h1, 1'b1, 1'b0, 32'h0000BBCC, 3);
    op(24'h034009, 2'h1, 1'b1, 1'b0, 32'h0000DDEE, 5);
    op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h00000022, 3);
    op(24'h034002, 2'h1, 1'b0, 1'b0, 32'h00003344, 3);
    op(24'h034000, 2'h2, 1'b0, 1'b0, 32'h11223344, 5);
    op(24'h034009, 2'h1, 1'b0, 1'b0, 32'h0000DDEE, 5);
    op(24'h034005, 2'h0, 1'b0, 1'b0, 32'h000000AA, 3);
    op(24'h034006, 2'h1, 1'b0, 1'b0, 32'h0000BBCC, 3);
    op(24'h035001, 2'h0, 1'b0, 1'b0, 32'h0, 8);
    for (int s = 0; s < 4; s++) begin
      wr(3'h0, {2'b00, 2'(s), 12'h000});
      op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h22, s[0] ? 8 : 3);
      op(24'h034001, 2'h0, 1'b0, 1'b1, 32'h22, 3);
    end
    wr(3'h0, 16'h0000);
    backup_supply <= 1'b1;
    repeat (3) @(posedge clk_sys);
    op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h0, 8);
    backup_supply <= 1'b0;
    repeat (3) @(posedge clk_sys);
    op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h22, 3);
    wr(3'h0, 16'h8000);
    wr(3'h4, 16'h0010);
    wr(3'h6, 16'h0000);
    wr(3'h0, 16'h0000);
    op(24'h100001, 2'h0, 1'b0, 1'b0, 32'h0, 8);
    wr(3'h0, 16'h8000);
    map_run();
    op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h22, 3);
    // Two frozen clocks in mid-access stretch it by two
    fork
      op(24'h034001, 2'h0, 1'b0, 1'b0, 32'h22, 5);
      begin
        repeat (2) @(posedge clk_sys);
        clk_en <= 1'b0;
        #1;
        `CHK(acc_busy, 1'b1)
        repeat (2) @(posedge clk_sys);
        clk_en <= 1'b1;
      end
    join
    wr(3'h0, 16'hC000);
    chk_reg(3'h0, 16'hC000);
    wr(3'h0, 16'h8000);
    chk_reg(3'h0, 16'hC000);
    wr(3'h4, 16'h0009);
    chk_reg(3'h4, 16'h0003);
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_reg(3'h0, 16'h8000);
    chk_reg(3'h4, 16'h0000);
    soft_case(24'h034000, 2, 2'h2, 3, 32'h0000FFFF, 32'h00001122);
    soft_case(24'h034000, 4, 2'h2, 5, 32'hFFFFFFFF, 32'h11223344);
    soft_case(24'h034000, 2, 2'h1, 3, 32'h0000FFFF, 32'h00001122);
    soft_case(24'h034009, 2, 2'h1, 5, 32'h0000FFFF, 32'h0000DDEE);
    // Array laid over the register block hides it until a reset
    wr(3'h4, 16'h00FF);
    wr(3'h6, 16'hF000);
    wr(3'h0, 16'h0000);
    chk_reg(3'h0, 16'h0000);
    wr(3'h0, 16'h8000);
    op(24'hFFF001, 2'h0, 1'b0, 1'b0, 32'h22, 3);
    op(24'hFFFB41, 2'h0, 1'b0, 1'b0, 32'h0, 8);
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_reg(3'h0, 16'h8000);
    end_sim();
  end
endmodule
`default_nettype wire
